//--- rtl/mca_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "mca_map.svh"

module mca_top (
   // clock and reset
   input  wire logic                clock,
   input  wire logic                sys_rst,
   // register port
   input  wire mca_pkg::mca_bus_req_t bus_req,
   output logic [7:0]               bus_rdata,
   // pins and datapath
   input  wire logic                transmit_power_enable_in,
   input  wire logic                rx_diversity_choice,
   input  wire logic                data_dqpsk_cfg,
   output logic                     antenna_choice_out,
   output mca_pkg::mca_tx_fmt_t     tx_format,
   output logic                     sfd_timer_enable,
   output logic                     length_timeout_enable
);

   // all block state lives in one struct, registered once per edge
   mca_pkg::mca_state_t    state_reg;
   mca_pkg::mca_state_t    state_next;

   // register port decode
   logic                   hit_config_a;
   logic                   hit_config_c;
   logic                   hit_status;
   logic                   wr_config_a;
   logic                   wr_config_c;
   logic                   rd_config_a;
   logic                   rd_config_c;
   logic                   rd_status;

   // register values as the port sees them
   logic [7:0]             wdata_config_a;
   logic [7:0]             wdata_config_c;
   logic [7:0]             status_word;
   logic [7:0]             rdata_next;

   // antenna select path
   logic                   dual_antenna;
   logic                   full_duplex;
   logic                   tx_active;
   logic                   tx_choice;
   logic                   rx_choice;
   logic [1:0]             ant_path;
   logic                   antenna_next;

   // transmit format path
   mca_pkg::mca_hdr_mode_t hdr_mode;
   mca_pkg::mca_tx_fmt_t   fmt_next;
   logic                   data_dqpsk_allowed;

   always_comb begin
      state_next = state_reg;

      // pin crosses into clock domain through two flops
      state_next.tx_meta = transmit_power_enable_in;
      state_next.tx_sync = state_reg.tx_meta;
      tx_active          = state_reg.tx_sync;

      // one decode shared by the write and the read side
      hit_config_a = (bus_req.addr == `MCA_OFS_CONFIG_A);
      hit_config_c = (bus_req.addr == `MCA_OFS_CONFIG_C);
      hit_status   = (bus_req.addr == `MCA_OFS_STATUS);

      wr_config_a  = bus_req.wr && hit_config_a;
      wr_config_c  = bus_req.wr && hit_config_c;

      rd_config_a  = bus_req.rd && hit_config_a;
      rd_config_c  = bus_req.rd && hit_config_c;
      rd_status    = bus_req.rd && hit_status;

      // unused bits dropped on the way in, so they read back 0
      wdata_config_a = bus_req.wdata & `MCA_A_WR_MASK;
      wdata_config_c = bus_req.wdata & `MCA_C_WR_MASK;

      // status is read only; a write there falls away
      if (wr_config_a) begin
         state_next.config_a = wdata_config_a;
      end
      if (wr_config_c) begin
         state_next.config_c = wdata_config_c;
      end

      status_word                  = 8'h00;
      status_word[`MCA_ST_ANT_BIT] = state_reg.antenna;
      status_word[`MCA_ST_TX_BIT]  = state_reg.tx_sync;

      // read data stands one cycle only, 0 otherwise
      rdata_next = 8'h00;
      if (rd_config_a) begin
         rdata_next = state_reg.config_a;
      end
      if (rd_config_c) begin
         rdata_next = state_reg.config_c;
      end
      if (rd_status) begin
         rdata_next = status_word;
      end
      state_next.rdata = rdata_next;

      dual_antenna = state_reg.config_c[`MCA_C_DUAL_ANT_BIT];
      full_duplex  = state_reg.config_a[`MCA_A_FULL_DPX_BIT];
      tx_choice    = state_reg.config_a[`MCA_A_TX_ANT_BIT];

      // dual antenna hands the receive choice to diversity logic
      if (dual_antenna) begin
         rx_choice = rx_diversity_choice;
      end else begin
         rx_choice = state_reg.config_a[`MCA_A_RX_ANT_BIT];
      end

      // full duplex never looks at transmit enable
      ant_path = {full_duplex, tx_active};
      unique case (ant_path)
         2'b00: begin
            antenna_next = rx_choice;
         end
         2'b01: begin
            antenna_next = tx_choice;
         end
         2'b10: begin
            antenna_next = rx_choice;
         end
         2'b11: begin
            antenna_next = rx_choice;
         end
      endcase
      // registered output, so it trails its causes by one edge
      state_next.antenna = antenna_next;

      hdr_mode = mca_pkg::mca_hdr_mode_t'({state_reg.config_a[`MCA_A_HDR_HI_BIT],
                                           state_reg.config_a[`MCA_A_HDR_LO_BIT]});

      // mode 0 pins the data to DBPSK; others pass the setting through
      data_dqpsk_allowed = (hdr_mode != mca_pkg::MCA_HDR_SFD);

      fmt_next              = '0;
      fmt_next.mode         = hdr_mode;
      fmt_next.sfd          = 1'b1;
      fmt_next.header_dbpsk = 1'b1;
      fmt_next.data_dqpsk   = data_dqpsk_allowed && data_dqpsk_cfg;

      unique case (hdr_mode)
         mca_pkg::MCA_HDR_SFD: begin
            fmt_next.crc16       = 1'b0;
            fmt_next.length      = 1'b0;
            fmt_next.full_header = 1'b0;
         end
         mca_pkg::MCA_HDR_SFD_CRC: begin
            fmt_next.crc16       = 1'b1;
            fmt_next.length      = 1'b0;
            fmt_next.full_header = 1'b0;
         end
         mca_pkg::MCA_HDR_SFD_LEN: begin
            fmt_next.crc16       = 1'b1;
            fmt_next.length      = 1'b1;
            fmt_next.full_header = 1'b0;
         end
         mca_pkg::MCA_HDR_FULL: begin
            fmt_next.crc16       = 1'b1;
            fmt_next.length      = 1'b1;
            fmt_next.full_header = 1'b1;
         end
      endcase
      state_next.fmt = fmt_next;
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         state_reg          <= '0;
         state_reg.config_a <= `MCA_RST_CONFIG_A;
         state_reg.config_c <= `MCA_RST_CONFIG_C;
         state_reg.fmt.sfd  <= 1'b1;
         state_reg.fmt.header_dbpsk <= 1'b1;
      end else begin
         state_reg <= state_next;
      end
   end

   assign bus_rdata             = state_reg.rdata;
   assign antenna_choice_out    = state_reg.antenna;
   assign tx_format             = state_reg.fmt;
   assign sfd_timer_enable      = state_reg.config_a[`MCA_A_SFD_TMR_BIT];
   assign length_timeout_enable = state_reg.config_a[`MCA_A_LEN_TMO_BIT];

endmodule
`default_nettype wire

//--- rtl/mca_map.svh
`ifndef MCA_MAP_SVH
`define MCA_MAP_SVH

`define MCA_ADDR_W          8
`define MCA_OFS_CONFIG_A    8'h00
`define MCA_OFS_CONFIG_C    8'h08
`define MCA_OFS_STATUS      8'hF0

`define MCA_A_TX_ANT_BIT    7
`define MCA_A_RX_ANT_BIT    6
`define MCA_A_FULL_DPX_BIT  5
`define MCA_A_HDR_HI_BIT    4
`define MCA_A_HDR_LO_BIT    3
`define MCA_A_SFD_TMR_BIT   2
`define MCA_A_LEN_TMO_BIT   1
`define MCA_A_WR_MASK       8'hFE
`define MCA_C_DUAL_ANT_BIT  2
`define MCA_C_WR_MASK       8'h04

`define MCA_RST_CONFIG_A    8'h00
`define MCA_RST_CONFIG_C    8'h00

`define MCA_ST_ANT_BIT      0
`define MCA_ST_TX_BIT       1

`endif

//--- rtl/mca_pkg.sv
package mca_pkg;

   typedef enum logic [1:0] {
      MCA_HDR_SFD      = 2'h0,
      MCA_HDR_SFD_CRC  = 2'h1,
      MCA_HDR_SFD_LEN  = 2'h2,
      MCA_HDR_FULL     = 2'h3
   } mca_hdr_mode_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } mca_bus_req_t;

   typedef struct packed {
      logic          sfd;
      logic          crc16;
      logic          length;
      logic          full_header;
      logic          header_dbpsk;
      logic          data_dqpsk;
      mca_hdr_mode_t mode;
   } mca_tx_fmt_t;

   typedef struct packed {
      logic [7:0]  config_a;
      logic [7:0]  config_c;
      logic        tx_meta;
      logic        tx_sync;
      logic [7:0]  rdata;
      logic        antenna;
      mca_tx_fmt_t fmt;
   } mca_state_t;

endpackage

//--- sim/mca_properties.sv
`timescale 1ns/10ps
`default_nettype none
module mca_properties (
   // watched top ports
   input wire logic                  clock,
   input wire logic                  sys_rst,
   input wire mca_pkg::mca_bus_req_t bus_req,
   input wire logic                  data_dqpsk_cfg,
   input wire mca_pkg::mca_tx_fmt_t  tx_format
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   a_mode_follows: assert property (bus_req.wr && bus_req.addr == 8'h00 |=>
      ##1 tx_format.mode == $past(bus_req.wdata[4:3], 2)) else $error("mode");
   a_hdr_dbpsk: assert property (tx_format.header_dbpsk) else $error("hdr");
   a_mode0_data: assert property (tx_format.mode == 2'h0 |->
      !tx_format.data_dqpsk) else $error("m0");
   a_data_cfg: assert property (tx_format.mode != 2'h0 |->
      tx_format.data_dqpsk == $past(data_dqpsk_cfg)) else $error("dq");
   a_sfd_always: assert property (tx_format.sfd) else $error("sfd");
   a_crc_modes: assert property (tx_format.crc16 == (tx_format.mode != 2'h0))
      else $error("crc");
   a_len_modes: assert property (tx_format.length == tx_format.mode[1])
      else $error("len");
   a_full_hdr: assert property (tx_format.full_header == (tx_format.mode == 2'h3))
      else $error("full");
endmodule
bind mca_top mca_properties mca_properties_inst (.clock, .sys_rst, .bus_req, .data_dqpsk_cfg,
   .tx_format);
`default_nettype wire

//--- sim/mca_host.sv
`timescale 1ns/10ps
`default_nettype none
module mca_host (
   // bus side and transmit enable pin
   input  wire logic                 clock,
   output var mca_pkg::mca_bus_req_t bus_req,
   output var logic                  tx_en,
   input  wire logic [7:0]           bus_rdata
);
   initial begin
      bus_req = '0;
      tx_en = 1'b0;
   end
   // data stands one cycle only, so taken just after it lands
   task automatic acc(input logic w, input logic [7:0] a, d, output logic [7:0] q);
      @(posedge clock);
      bus_req <= '{addr: a, wdata: d, wr: w, rd: !w};
      @(posedge clock);
      bus_req <= '0;
      #1 q = bus_rdata;
   endtask
   // raised only after config writes
   task automatic set_tx(input logic t);
      @(posedge clock);
      tx_en <= t;
   endtask
endmodule
`default_nettype wire

//--- sim/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
   logic                  clock, sys_rst, tx_en, rxd, dq, ant, sfdt, lent;
   logic [7:0]            rdata, q;
   mca_pkg::mca_bus_req_t req;
   mca_pkg::mca_tx_fmt_t  fmt;
   int                    miscompares = 0, compares = 0, seed = 52, a, c, e, ae;
   mca_top mca_top_inst (.clock, .sys_rst, .bus_req(req), .bus_rdata(rdata),
      .transmit_power_enable_in(tx_en), .rx_diversity_choice(rxd), .data_dqpsk_cfg(dq),
      .antenna_choice_out(ant), .tx_format(fmt), .sfd_timer_enable(sfdt),
      .length_timeout_enable(lent));
   mca_host mca_host_inst (.clock, .bus_req(req), .tx_en, .bus_rdata(rdata));
   task automatic chk(input string n, input logic [7:0] x, y);
      compares++;
      if (x !== y) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", n, x, y);
      end
   endtask
   task automatic wrap_up;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   function automatic int ant_model(int a, int c, int t, int r);
      int rx = c[2] ? r : a[6];
      return (!a[5] && t) ? a[7] : rx;
   endfunction
   initial begin
      clock = 0;
      forever #20 clock = ~clock;
   end
   initial begin
      #400000 miscompares++;
      wrap_up;
   end
   initial begin
      sys_rst = 1;
      rxd = 0;
      dq = 0;
      repeat (8) @(posedge clock);
      sys_rst <= 0;
      mca_host_inst.acc(0, 8'h44, 0, q);
      chk("unmapped", 0, q);
      for (int i = 0; i < 40; i++) begin
         a = $random(seed);
         c = $random(seed);
         mca_host_inst.set_tx(0);
         mca_host_inst.acc(1, 8'h00, a[7:0], q);
         mca_host_inst.acc(1, 8'h08, c[7:0], q);
         mca_host_inst.acc(0, 8'h00, 0, q);
         chk("config_a", a[7:0] & 8'hFE, q);
         mca_host_inst.acc(0, 8'h08, 0, q);
         chk("config_c", c[7:0] & 8'h04, q);
         mca_host_inst.set_tx(c[10]);
         rxd <= c[8];
         dq <= c[9];
         repeat (4) @(posedge clock);
         #1;
         e = a[4:3];
         ae = ant_model(a, c, c[10], c[8]);
         chk("antenna", ae, ant);
         chk("mode", e, fmt.mode);
         chk("format", {1'b1, e != 0, e[1], e == 3, 1'b1, e != 0 && c[9]}, fmt[7:2]);
         chk("timer_enables", {a[2], a[1]}, {sfdt, lent});
         mca_host_inst.acc(0, 8'hF0, 0, q);
         chk("status", {6'h00, c[10], ae[0]}, q);
      end
      // second reset in mid-run, outputs back to their reset levels
      @(posedge clock);
      sys_rst <= 1;
      repeat (3) @(posedge clock);
      sys_rst <= 0;
      #1;
      chk("reset_ant", 0, ant);
      chk("reset_fmt", 8'h88, fmt);
      chk("reset_enables", 0, {sfdt, lent});
      mca_host_inst.acc(0, 8'h00, 0, q);
      chk("reset_config_a", 0, q);
      mca_host_inst.acc(0, 8'h08, 0, q);
      chk("reset_config_c", 0, q);
      wrap_up;
   end
endmodule
`default_nettype wire
